// File: udc_regs.svh
// constants for the serial dma channel control block
`ifndef UDC_REGS_SVH
`define UDC_REGS_SVH
`define UDC_WID_1B        2'd0
`define UDC_WID_2B        2'd1
`define UDC_WID_4B        2'd2
`define UDC_BURST_MAX_LOG 3'd7
`define UDC_BUF_BYTES     7'd64
`define UDC_BURST_CAP     7'd32
`define UDC_DESC_WORDS    3'd4
`define UDC_LTR_IDLE      16'h0000
`define UDC_LTR_ACTIVE_NS 16'd1000
`endif

// File: udc_pkg.sv
// types for the serial dma channel control block
package udc_pkg;
  typedef enum logic [2:0] {
    UDC_ST_IDLE,
    UDC_ST_DESC,
    UDC_ST_WAIT,
    UDC_ST_RD,
    UDC_ST_WR,
    UDC_ST_DONE
  } udc_state_t;
endpackage

// File: udc_rst_ctl.sv
// per-controller software-released reset
`timescale 1ns/1ps
`include "udc_regs.svh"
module udc_rst_ctl
  import udc_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // software reset register
  input  wire logic sw_rst_wr,
  input  wire logic sw_rst_release,
  // controller reset out
  output logic      ctl_run
);
  typedef struct packed {
    logic run;
  } udc_rst_t;
  udc_rst_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (sw_rst_wr) begin
      s_d.run = sw_rst_release;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign ctl_run = s_q.run;
endmodule

// File: udc_pin_hold.sv
// hold serial outputs at their last value while power gated
`timescale 1ns/1ps
`include "udc_regs.svh"
module udc_pin_hold
  import udc_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // gating control
  input  wire logic pwr_gate,
  // serial outputs from controller
  input  wire logic txd_in,
  input  wire logic rts_b_in,
  // serial outputs to pins
  output logic      txd_out,
  output logic      rts_b_out
);
  typedef struct packed {
    logic txd;
    logic rts_b;
  } udc_pin_t;
  udc_pin_t s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (!pwr_gate) begin
      s_d.txd   = txd_in;
      s_d.rts_b = rts_b_in;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end
  assign txd_out   = s_q.txd;
  assign rts_b_out = s_q.rts_b;
endmodule

// File: udc_dma_chan.sv
// serial dma channel control top
`timescale 1ns/1ps
`include "udc_regs.svh"
// What this block does
// (RL1) source and destination widths chosen independently: one, two or four bytes
// (RL2) separate source and destination burst lengths, powers of two up to 128
// (RL3) bytes per burst equal burst length times that side's width, capped at 32 bytes
// (RL4) block length in bytes, any value, packing between unequal widths
// (RL5) each side's address increments per transfer or stays constant
// (RL6) any handshake request line can be mapped to this channel
// (RL7) early termination stops this channel only
// (RL8) channel has its own enable; idle channel may be clock gated once disabled or held in reset
// (RL9) controller has its own software reset register
// (RL10) controller and dma held in reset until software releases them
// (RL11) serial outputs held at their last value while power gated
// (RL12) default latency report follows activity: active value busy, none idle
// (RL13) driver scheme reports the software written latency value
// (RL14) one interrupt line merges controller, dma and transmit-done sources
// (RL15) interrupts active high, level, held until status cleared
// (RL16) serial line errors captured in status for the driver
// (RL17) 8 byte buffer; no burst beyond 32 bytes
// (RL18) peripheral handshake paces transfers to and from memory
// (RL19) descriptors fetched from memory load registers and chain blocks
// (RL20) packing is ascending address order, least significant byte first
module udc_dma_chan
  import udc_pkg::*;
#(
  parameter int NUM_HS = 8,
  parameter int AW     = 32
)(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // software reset and power
  input  wire logic              sw_rst_wr,
  input  wire logic              sw_rst_release,
  input  wire logic              pwr_gate,
  // channel configuration
  input  wire logic              ch_enable,
  input  wire logic              ch_start,
  input  wire logic              ch_abort,
  input  wire logic              ch_desc_mode,
  input  wire logic [AW-1:0]     ch_desc_addr,
  input  wire logic [1:0]        ch_src_width,
  input  wire logic [1:0]        ch_dst_width,
  input  wire logic [2:0]        ch_src_burst_log,
  input  wire logic [2:0]        ch_dst_burst_log,
  input  wire logic              ch_src_inc,
  input  wire logic              ch_dst_inc,
  input  wire logic [AW-1:0]     ch_src_addr,
  input  wire logic [AW-1:0]     ch_dst_addr,
  input  wire logic [15:0]       ch_block_bytes,
  input  wire logic [$clog2(NUM_HS)-1:0] ch_hs_sel,
  // handshake from peripherals
  input  wire logic [NUM_HS-1:0] hs_req,
  output logic      [NUM_HS-1:0] hs_ack,
  // memory bus, one transfer at a time
  output logic                   mem_req,
  output logic                   mem_we,
  output logic      [AW-1:0]     mem_addr,
  output logic      [31:0]       mem_wdata,
  output logic      [3:0]        mem_be,
  input  wire logic              mem_ack,
  input  wire logic [31:0]       mem_rdata,
  // latency tolerance
  input  wire logic              ltr_drv_mode,
  input  wire logic [15:0]       ltr_drv_value,
  output logic      [15:0]       ltr_value,
  // interrupts and status
  input  wire logic              hc_irq,
  input  wire logic              tx_done_irq,
  input  wire logic              line_err,
  input  wire logic              dma_clr,
  input  wire logic              err_clr,
  output logic                   dma_done_sts,
  output logic                   line_err_sts,
  output logic                   irq,
  // status
  output logic                   ch_busy,
  output logic                   ctl_run,
  output logic                   ch_clk_en,
  // serial pins
  input  wire logic              txd_in,
  input  wire logic              rts_b_in,
  output logic                   txd_out,
  output logic                   rts_b_out
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] wbytes(input logic [1:0] w);
    unique case (w)
      `UDC_WID_1B: wbytes = 3'd1;
      `UDC_WID_2B: wbytes = 3'd2;
      default:     wbytes = 3'd4;
    endcase
  endfunction

  // bytes per burst, capped by buffer burst limit
  function automatic logic [7:0] burst_bytes(input logic [1:0] w, input logic [2:0] l);
    logic [10:0] b;
    b = 11'({8'd0, wbytes(w)} << l);
    if (b > 11'(`UDC_BURST_CAP)) begin
      b = 11'(`UDC_BURST_CAP);
    end
    burst_bytes = b[7:0];
  endfunction

  // keep only the bytes a beat really carries
  function automatic logic [31:0] beat_mask(input logic [2:0] n);
    beat_mask = 32'((33'h0_0000_0001 << {n, 3'b000}) - 33'h0_0000_0001);
  endfunction

  // ----------------------------------------
  // sub blocks
  // ----------------------------------------
  udc_rst_ctl u_rst (
    .clk_sys        (clk_sys),
    .rst_b          (rst_b),
    .sw_rst_wr      (sw_rst_wr),
    .sw_rst_release (sw_rst_release),
    .ctl_run        (ctl_run)
  ); // RL9 RL10

  udc_pin_hold u_pin (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .pwr_gate  (pwr_gate),
    .txd_in    (txd_in),
    .rts_b_in  (rts_b_in),
    .txd_out   (txd_out),
    .rts_b_out (rts_b_out)
  ); // RL11

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    udc_state_t      st;
    logic [AW-1:0]   saddr;
    logic [AW-1:0]   daddr;
    logic [15:0]     left;
    logic [7:0]      bcnt;
    logic [63:0]     buf_data;
    logic [6:0]      fill;
    logic [AW-1:0]   dptr;
    logic [2:0]      dword;
    logic [1:0]      sw;
    logic [1:0]      dw;
    logic [2:0]      sbl;
    logic [2:0]      dbl;
    logic            sinc;
    logic            dinc;
    logic            done;
    logic            lerr;
    logic            ack;
  } udc_chan_t;
  udc_chan_t s_q, s_d;

  logic       run;
  logic       req_sel;
  logic [2:0] sbytes;
  logic [2:0] dbytes;
  logic [2:0] rd_n;
  logic [2:0] wr_n;
  logic [15:0] need;
  logic [6:0]  room;
  logic [2:0]  rd_lim;

  assign run     = ctl_run && ch_enable; // RL8 RL10
  assign req_sel = hs_req[ch_hs_sel]; // RL6
  assign sbytes  = wbytes(s_q.sw); // RL1
  assign dbytes  = wbytes(s_q.dw); // RL1
  // clamp each beat to bytes still needed
  // fetch only bytes not yet buffered, and only what fits
  assign need   = s_q.left - 16'(s_q.fill); // RL4
  assign room   = 7'h08 - s_q.fill; // RL17
  assign rd_lim = (need < 16'(sbytes)) ? need[2:0] : sbytes; // RL4
  assign rd_n   = (room < 7'(rd_lim)) ? room[2:0] : rd_lim; // RL17
  assign wr_n = (s_q.left < 16'(dbytes)) ? s_q.left[2:0] : dbytes; // RL4

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    // sticky status, set beats clear
    if (dma_clr) begin
      s_d.done = 1'b0;
    end
    if (err_clr) begin
      s_d.lerr = 1'b0;
    end
    if (line_err) begin
      s_d.lerr = 1'b1; // RL16
    end
    unique case (s_q.st)
      UDC_ST_IDLE: begin
        if (run && ch_start) begin
          s_d.sw    = ch_src_width;
          s_d.dw    = ch_dst_width;
          s_d.sbl   = ch_src_burst_log; // RL2
          s_d.dbl   = ch_dst_burst_log; // RL2
          s_d.sinc  = ch_src_inc;
          s_d.dinc  = ch_dst_inc;
          s_d.fill  = '0;
          s_d.dptr  = ch_desc_addr;
          s_d.dword = '0;
          if (ch_desc_mode) begin
            s_d.st = UDC_ST_DESC; // RL19
          end else begin
            s_d.saddr = ch_src_addr;
            s_d.daddr = ch_dst_addr;
            s_d.left  = ch_block_bytes;
            s_d.st    = (ch_block_bytes == 16'h0000) ? UDC_ST_DONE : UDC_ST_WAIT;
          end
        end
      end
      UDC_ST_DESC: begin
        // words: src, dst, bytes, next pointer (zero ends chain)
        if (mem_ack) begin
          unique case (s_q.dword)
            3'd0: s_d.saddr = AW'(mem_rdata);
            3'd1: s_d.daddr = AW'(mem_rdata);
            3'd2: s_d.left  = mem_rdata[15:0];
            default: s_d.dptr = AW'(mem_rdata);
          endcase
          s_d.dword = s_q.dword + 3'd1;
          if (s_q.dword == `UDC_DESC_WORDS - 3'd1) begin
            s_d.st = (s_q.left == 16'h0000) ? UDC_ST_DONE : UDC_ST_WAIT; // RL19
          end
        end
      end
      UDC_ST_WAIT: begin
        if (req_sel) begin
          s_d.ack  = 1'b1; // RL18
          s_d.bcnt = burst_bytes(s_q.sw, s_q.sbl); // RL3 RL17
          s_d.st   = UDC_ST_RD;
        end
      end
      UDC_ST_RD: begin
        if (mem_ack) begin
          // append bytes above those held, lowest address first
          s_d.buf_data = s_q.buf_data |
                         (64'(mem_rdata & beat_mask(rd_n)) << {s_q.fill[3:0], 3'b000}); // RL20
          s_d.fill     = s_q.fill + 7'(rd_n);
          s_d.bcnt     = (s_q.bcnt > 8'(rd_n)) ? s_q.bcnt - 8'(rd_n) : 8'd0;
          if (s_q.sinc) begin
            s_d.saddr = s_q.saddr + AW'(rd_n); // RL5
          end
          if (s_q.bcnt <= 8'(rd_n) || need <= 16'(rd_n) ||
              s_q.fill + 7'(rd_n) >= 7'(dbytes) + 7'd4) begin
            s_d.bcnt = burst_bytes(s_q.dw, s_q.dbl); // RL3 RL17
            s_d.st   = UDC_ST_WR;
          end
        end
      end
      UDC_ST_WR: begin
        if (s_q.fill < 7'(wr_n) && s_q.left > 16'(s_q.fill)) begin
          s_d.st = UDC_ST_WAIT; // need more source bytes
        end else if (mem_ack) begin
          s_d.buf_data = s_q.buf_data >> {wr_n, 3'b000}; // RL20
          s_d.fill     = s_q.fill - 7'(wr_n);
          s_d.left     = s_q.left - 16'(wr_n);
          s_d.bcnt     = (s_q.bcnt > 8'(wr_n)) ? s_q.bcnt - 8'(wr_n) : 8'd0;
          if (s_q.dinc) begin
            s_d.daddr = s_q.daddr + AW'(wr_n); // RL5
          end
          if (s_q.left == 16'(wr_n)) begin
            if (s_q.dptr != '0 && ch_desc_mode) begin
              s_d.dword = '0;
              s_d.fill  = '0;
              s_d.st    = UDC_ST_DESC; // RL19
            end else begin
              s_d.st = UDC_ST_DONE;
            end
          end else if (s_q.bcnt <= 8'(wr_n) ||
                       (s_q.fill - 7'(wr_n) < 7'(dbytes) && need != 16'h0000)) begin
            s_d.st = UDC_ST_WAIT; // RL18
          end
        end
      end
      UDC_ST_DONE: begin
        s_d.done = 1'b1; // RL15
        s_d.st   = UDC_ST_IDLE;
      end
    endcase
    // early stop of this channel only, or disable / reset
    if ((ch_abort || !run) && s_q.st != UDC_ST_IDLE && s_q.st != UDC_ST_DONE) begin
      s_d.st       = UDC_ST_DONE; // RL7 RL8
      s_d.buf_data = '0;
      s_d.fill     = '0;
    end
    if (s_q.st == UDC_ST_WR && s_d.st != UDC_ST_WR && s_d.fill == '0) begin
      s_d.buf_data = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic [3:0] be_rd;
  logic [3:0] be_wr;
  assign be_rd = 4'((5'h01 << rd_n) - 5'h01);
  assign be_wr = 4'((5'h01 << wr_n) - 5'h01);

  always_comb begin
    mem_req   = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = '0;
    mem_wdata = '0;
    mem_be    = 4'h0;
    unique case (s_q.st)
      UDC_ST_DESC: begin
        mem_req  = 1'b1;
        mem_addr = s_q.dptr + AW'({s_q.dword, 2'b00});
        mem_be   = 4'hf;
      end
      UDC_ST_RD: begin
        mem_req  = 1'b1;
        mem_addr = s_q.saddr;
        mem_be   = be_rd;
      end
      UDC_ST_WR: begin
        mem_req   = !(s_q.fill < 7'(wr_n) && s_q.left > 16'(s_q.fill));
        mem_we    = 1'b1;
        mem_addr  = s_q.daddr;
        mem_wdata = s_q.buf_data[31:0];
        mem_be    = be_wr;
      end
      default: begin
        mem_req = 1'b0;
      end
    endcase
  end

  assign hs_ack       = s_q.ack ? (NUM_HS'(1) << ch_hs_sel) : '0; // RL6 RL18
  assign ch_busy      = (s_q.st != UDC_ST_IDLE);
  assign ch_clk_en    = run || ch_busy; // RL8
  assign dma_done_sts = s_q.done;
  assign line_err_sts = s_q.lerr; // RL16
  assign irq          = s_q.done || s_q.lerr || hc_irq || tx_done_irq; // RL14 RL15
  assign ltr_value    = ltr_drv_mode ? ltr_drv_value // RL13
                      : (ch_busy ? `UDC_LTR_ACTIVE_NS : `UDC_LTR_IDLE); // RL12
endmodule

// File: udc_dma_chan_monitor.sv
// checker for the serial dma channel ports
`timescale 1ns/1ps
`include "udc_regs.svh"
module udc_dma_chan_monitor #(
  parameter int NUM_HS = 8,
  parameter int AW     = 32
)(
  // clock and reset
  input wire logic                      clk_sys,
  input wire logic                      rst_b,
  // controls
  input wire logic                      sw_rst_wr,
  input wire logic                      sw_rst_release,
  input wire logic                      pwr_gate,
  input wire logic                      ch_abort,
  input wire logic [$clog2(NUM_HS)-1:0] ch_hs_sel,
  input wire logic [NUM_HS-1:0]         hs_req,
  input wire logic                      ltr_drv_mode,
  input wire logic [15:0]               ltr_drv_value,
  input wire logic                      hc_irq,
  input wire logic                      tx_done_irq,
  input wire logic                      line_err,
  input wire logic                      err_clr,
  input wire logic                      txd_in,
  input wire logic                      rts_b_in,
  // outputs
  input wire logic [NUM_HS-1:0]         hs_ack,
  input wire logic                      mem_req,
  input wire logic [15:0]               ltr_value,
  input wire logic                      dma_done_sts,
  input wire logic                      line_err_sts,
  input wire logic                      irq,
  input wire logic                      ch_busy,
  input wire logic                      ctl_run,
  input wire logic                      txd_out,
  input wire logic                      rts_b_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_run_release: assert property (sw_rst_wr && sw_rst_release |=> ctl_run)
    else $error("ctl_run not set by release write");
  a_held_reset: assert property (!ctl_run && !$past(ctl_run) && !$past(ctl_run, 2)
                                 |-> !mem_req && !ch_busy)
    else $error("channel active while held in reset");
  a_pins_frozen: assert property ($past(pwr_gate) |-> $stable(txd_out) && $stable(rts_b_out))
    else $error("serial pin moved while gated");
  a_pins_follow: assert property (!pwr_gate |=> txd_out == $past(txd_in) && rts_b_out == $past(rts_b_in))
    else $error("serial pin not following controller");
  a_ltr_auto: assert property (!ltr_drv_mode |-> ltr_value == (ch_busy ? `UDC_LTR_ACTIVE_NS : `UDC_LTR_IDLE))
    else $error("latency value not following activity");
  a_ltr_driver: assert property (ltr_drv_mode |-> ltr_value == ltr_drv_value)
    else $error("latency value not the written one");
  a_irq_merge: assert property (irq == (dma_done_sts || line_err_sts || hc_irq || tx_done_irq))
    else $error("irq not the merge of its sources");
  a_err_sticky: assert property (line_err || (line_err_sts && !err_clr) |=> line_err_sts)
    else $error("line error status lost");
  a_ack_selected: assert property (|hs_ack |-> hs_ack == (NUM_HS'(1) << ch_hs_sel) && $past(hs_req[ch_hs_sel]))
    else $error("ack on wrong line or without request");
  a_abort_stop: assert property (ch_abort |-> ##[1:2] !ch_busy)
    else $error("channel still busy after abort");
endmodule
bind udc_dma_chan udc_dma_chan_monitor #(.NUM_HS(NUM_HS), .AW(AW)) mon_u (.clk_sys, .rst_b,
  .sw_rst_wr, .sw_rst_release, .pwr_gate, .ch_abort, .ch_hs_sel, .hs_req, .ltr_drv_mode,
  .ltr_drv_value, .hc_irq, .tx_done_irq, .line_err, .err_clr, .txd_in, .rts_b_in, .hs_ack,
  .mem_req, .ltr_value, .dma_done_sts, .line_err_sts, .irq, .ch_busy, .ctl_run, .txd_out,
  .rts_b_out);

// File: udc_mem_model.sv
// system memory partner on the dma memory bus
`timescale 1ns/1ps
module udc_mem_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // memory bus
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [3:0]  mem_be,
  input  wire logic        slow,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [7:0] mem [0:1023];
  int         cnt;
  initial for (int i = 0; i < 1024; i++) mem[i] = i[7:0];
  // one access at a time, data only in the ack cycle
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack <= 1'b0;
      cnt <= 0;
      mem_rdata <= 32'h5a5a_a5a5;
    end else if (mem_req && !mem_ack && cnt >= (slow ? 3 : 0)) begin
      mem_ack <= 1'b1;
      cnt <= 0;
      for (int i = 0; i < 4; i++) begin
        if (mem_we && mem_be[i]) mem[10'(mem_addr + i)] <= mem_wdata[8*i+:8];
        mem_rdata[8*i+:8] <= mem[10'(mem_addr + i)];
      end
    end else begin
      mem_ack <= 1'b0;
      cnt <= mem_req ? cnt + 1 : 0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// File: udc_tb.sv
// self-checking testbench for the serial dma channel
`timescale 1ns/1ps
`include "udc_regs.svh"
module testbench;
  logic        clk_sys, rst_b, sw_rst_wr, sw_rst_release, pwr_gate, ch_enable, ch_start;
  logic        ch_abort, ch_desc_mode, ch_src_inc, ch_dst_inc, ltr_drv_mode, hc_irq, slow;
  logic        tx_done_irq, line_err, dma_clr, err_clr, txd_in, rts_b_in, mem_req, mem_we;
  logic        mem_ack, irq, ch_busy, ctl_run, ch_clk_en, txd_out, rts_b_out;
  logic        dma_done_sts, line_err_sts;
  logic [31:0] ch_desc_addr, ch_src_addr, ch_dst_addr, mem_addr, mem_wdata, mem_rdata;
  logic [15:0] ch_block_bytes, ltr_drv_value, ltr_value;
  logic [2:0]  ch_src_burst_log, ch_dst_burst_log, ch_hs_sel;
  logic [1:0]  ch_src_width, ch_dst_width;
  logic [7:0]  hs_req, hs_ack;
  logic [3:0]  mem_be;
  int          mismatches, total_checks;
  udc_dma_chan #(.NUM_HS(8), .AW(32)) dut_u (.clk_sys, .rst_b, .sw_rst_wr, .sw_rst_release,
    .pwr_gate, .ch_enable, .ch_start, .ch_abort, .ch_desc_mode, .ch_desc_addr, .ch_src_width,
    .ch_dst_width, .ch_src_burst_log, .ch_dst_burst_log, .ch_src_inc, .ch_dst_inc,
    .ch_src_addr, .ch_dst_addr, .ch_block_bytes, .ch_hs_sel, .hs_req, .hs_ack, .mem_req,
    .mem_we, .mem_addr, .mem_wdata, .mem_be, .mem_ack, .mem_rdata, .ltr_drv_mode,
    .ltr_drv_value, .ltr_value, .hc_irq, .tx_done_irq, .line_err, .dma_clr, .err_clr,
    .dma_done_sts, .line_err_sts, .irq, .ch_busy, .ctl_run, .ch_clk_en, .txd_in, .rts_b_in,
    .txd_out, .rts_b_out);
  udc_mem_model mdl_u (.clk_sys, .rst_b, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_be,
    .slow, .mem_ack, .mem_rdata);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic go(input logic [31:0] s, input logic [31:0] d, input logic [15:0] n);
    @(posedge clk_sys);
    ch_src_addr <= s;
    ch_dst_addr <= d;
    ch_block_bytes <= n;
    ch_start <= 1'b1;
    @(posedge clk_sys);
    ch_start <= 1'b0;
  endtask
  task automatic fin;
    int w;
    w = 0;
    while (dma_done_sts !== 1'b1 && w < 4000) begin
      @(negedge clk_sys);
      w++;
    end
    chk(dma_done_sts, 1'b1);
    @(posedge clk_sys);
    dma_clr <= 1'b1;
    @(posedge clk_sys);
    dma_clr <= 1'b0;
    cyc(1);
    chk(dma_done_sts, 1'b0);
  endtask
  task automatic cmpb(input logic [31:0] s, input logic [31:0] d, input int n);
    for (int i = 0; i < n; i++) chk(mdl_u.mem[10'(d + i)], 8'(s + i));
    chk(mdl_u.mem[10'(d + n)], 8'(d + n));
  endtask
  task automatic put(input logic [9:0] a, input logic [31:0] v);
    for (int i = 0; i < 4; i++) mdl_u.mem[a + 10'(i)] = v[8*i+:8];
  endtask
  task automatic t_reset;
    go(32'h0000_0000, 32'h0000_03f0, 16'd4);
    cyc(10);
    chk(ctl_run, 1'b0);
    chk(ch_busy, 1'b0);
    @(posedge clk_sys);
    sw_rst_wr <= 1'b1;
    sw_rst_release <= 1'b1;
    @(posedge clk_sys);
    sw_rst_wr <= 1'b0;
    cyc(1);
    chk(ctl_run, 1'b1);
    $display("reset test done");
  endtask
  task automatic t_width;
    for (int k = 0; k < 9; k++) begin
      @(posedge clk_sys);
      ch_src_width <= 2'(k / 3);
      ch_dst_width <= 2'(k % 3);
      ch_src_burst_log <= 3'(k);
      ch_dst_burst_log <= 3'(7 - k % 8);
      ch_hs_sel <= 3'(k);
      hs_req <= 8'(1 << (k % 8));
      slow <= k[0];
      go(32'h0000_0040, 32'h0000_0100 + 32'(k * 16), 16'd7);
      fin();
      cmpb(32'h0000_0040, 32'h0000_0100 + 32'(k * 16), 7);
    end
    $display("width test done");
  endtask
  task automatic t_const;
    @(posedge clk_sys);
    ch_src_width <= `UDC_WID_1B;
    ch_dst_width <= `UDC_WID_1B;
    ch_src_inc <= 1'b0;
    ch_dst_inc <= 1'b0;
    go(32'h0000_00c5, 32'h0000_01c0, 16'd4);
    fin();
    chk(mdl_u.mem[10'h1c0], 8'hc5);
    chk(mdl_u.mem[10'h1c1], 8'hc1);
    @(posedge clk_sys);
    ch_src_inc <= 1'b1;
    go(32'h0000_00a0, 32'h0000_01d0, 16'd4);
    fin();
    chk(mdl_u.mem[10'h1d0], 8'ha3);
    chk(mdl_u.mem[10'h1d1], 8'hd1);
    @(posedge clk_sys);
    ch_dst_inc <= 1'b1;
    hs_req <= 8'h00;
    go(32'h0000_0060, 32'h0000_01a0, 16'd4);
    repeat (20) begin
      @(negedge clk_sys);
      chk(mem_req, 1'b0);
    end
    chk(ltr_value, `UDC_LTR_ACTIVE_NS);
    @(posedge clk_sys);
    hs_req <= 8'h01;
    cyc(2);
    chk(hs_ack, 8'h01);
    fin();
    cmpb(32'h0000_0060, 32'h0000_01a0, 4);
    $display("address and pacing test done");
  endtask
  task automatic t_stop;
    @(posedge clk_sys);
    hs_req <= 8'h00;
    go(32'h0000_0070, 32'h0000_01b0, 16'd4);
    @(posedge clk_sys);
    ch_abort <= 1'b1;
    @(posedge clk_sys);
    ch_abort <= 1'b0;
    cyc(3);
    chk(ch_busy, 1'b0);
    go(32'h0000_0070, 32'h0000_01b0, 16'd4);
    @(posedge clk_sys);
    ch_enable <= 1'b0;
    cyc(3);
    chk(ch_busy, 1'b0);
    chk(ch_clk_en, 1'b0);
    chk(mdl_u.mem[10'h1b0], 8'hb0);
    @(posedge clk_sys);
    ch_enable <= 1'b1;
    dma_clr <= 1'b1;
    hs_req <= 8'h01;
    @(posedge clk_sys);
    dma_clr <= 1'b0;
    $display("stop test done");
  endtask
  task automatic t_desc;
    put(10'h200, 32'h0000_0050);
    put(10'h204, 32'h0000_0300);
    put(10'h208, 32'h0000_0004);
    put(10'h20c, 32'h0000_0210);
    put(10'h210, 32'h0000_0060);
    put(10'h214, 32'h0000_0320);
    put(10'h218, 32'h0000_0004);
    put(10'h21c, 32'h0000_0000);
    @(posedge clk_sys);
    ch_src_width <= `UDC_WID_4B;
    ch_dst_width <= `UDC_WID_4B;
    ch_desc_mode <= 1'b1;
    ch_desc_addr <= 32'h0000_0200;
    go(32'h0000_0000, 32'h0000_0000, 16'd0);
    fin();
    cyc(40);
    chk(ch_busy, 1'b0);
    cmpb(32'h0000_0050, 32'h0000_0300, 4);
    cmpb(32'h0000_0060, 32'h0000_0320, 4);
    $display("descriptor test done");
  endtask
  task automatic t_misc;
    @(posedge clk_sys);
    pwr_gate <= 1'b1;
    txd_in <= 1'b0;
    rts_b_in <= 1'b0;
    cyc(3);
    chk({txd_out, rts_b_out}, 2'b11);
    @(posedge clk_sys);
    pwr_gate <= 1'b0;
    line_err <= 1'b1;
    @(posedge clk_sys);
    line_err <= 1'b0;
    cyc(1);
    chk({txd_out, rts_b_out, line_err_sts, irq}, 4'b0011);
    @(posedge clk_sys);
    err_clr <= 1'b1;
    hc_irq <= 1'b1;
    @(posedge clk_sys);
    err_clr <= 1'b0;
    hc_irq <= 1'b0;
    tx_done_irq <= 1'b1;
    ltr_drv_mode <= 1'b1;
    ltr_drv_value <= 16'h1234;
    cyc(1);
    chk({line_err_sts, irq}, 2'b01);
    chk(ltr_value, 16'h1234);
    @(posedge clk_sys);
    tx_done_irq <= 1'b0;
    ltr_drv_mode <= 1'b0;
    cyc(1);
    chk(irq, 1'b0);
    chk(ltr_value, `UDC_LTR_IDLE);
    $display("pin and status test done");
  endtask
  initial begin
    {rst_b, sw_rst_wr, sw_rst_release, pwr_gate, ch_start, ch_abort, ch_desc_mode} = '0;
    {ltr_drv_mode, hc_irq, tx_done_irq, line_err, dma_clr, err_clr, slow} = '0;
    {ch_enable, ch_src_inc, ch_dst_inc, txd_in, rts_b_in} = '1;
    {ch_desc_addr, ch_src_addr, ch_dst_addr, ch_block_bytes, ltr_drv_value} = '0;
    {ch_src_burst_log, ch_dst_burst_log, ch_hs_sel} = '0;
    ch_src_width = `UDC_WID_4B;
    ch_dst_width = `UDC_WID_4B;
    hs_req = 8'h01;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_width();
    t_const();
    t_stop();
    t_desc();
    t_misc();
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
endmodule
